// *** spm_pkg.sv ***
// shared constants and types for the supply and power mode sequencer
package spm_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int SYS_CLK_KHZ = 125000;
  localparam int FUSE_READ_US = 50;
  localparam int FUSE_READ_CYC = (FUSE_READ_US * SYS_CLK_KHZ) / 1000;
  localparam int ACTIVE_TIME_US = 100;
  localparam int ACTIVE_TIME_CYC = (ACTIVE_TIME_US * SYS_CLK_KHZ) / 1000;
  localparam int POLL_ACTIVE_CYC = 16;
  localparam int CNT_W = 24;
  localparam int CH_N = 22;
  localparam int POLL_SEL_W = 3;
  localparam logic [CNT_W-1:0] POLL_BASE_CYC = 24'h000400;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CH_N-1:0] WAKE_EN_RST = 22'h3FFFFF;
  localparam logic [POLL_SEL_W-1:0] POLL_SEL_RST = 3'h0;
  // ****************************************
  // states
  // ****************************************
  typedef enum logic [2:0] {
    SPM_ST_UV = 3'b000,
    SPM_ST_FUSE = 3'b001,
    SPM_ST_NORMAL = 3'b011,
    SPM_ST_LOWPWR = 3'b010,
    SPM_ST_POLL = 3'b110
  } spm_state_e;
endpackage

// *** spm_supply_and_power_mode_fsm.sv ***
// power state sequencer: lockout, fuse read, normal, low power and polling
// What this block does
// - lockout keeps serial data output tristated
// - lockout ignores chip select except in low power and polling, where a falling one still wakes
// - supply drop mid word discards word
// - lockout seen flag set after recovery
// - reset restores defaults, serial interface off
// - power on reset flag for host
// - overvoltage limits current sources, keeps registers
// - overvoltage end restores programmed current setup
// - interrupt held low until ready
// - logic up within activation time
// - io supply loss keeps state, resumes
// - lockout keeps registers, mux off, sources off
// - both oscillators run from lockout onward, except the fast one in low power
// - fuse read about 50 us, then normal
// - wake output low in normal mode
// - faults detected and reported in normal
// - low power entered only by command
// - low power stops fast clock and faults
// - wake sources: timer, int, cs, wake, comparator
// - poll inputs periodically against held state
// - undervoltage pauses polling without waking
// - poll end returns low power unless wake
// - no wake enables disables polling timer
`timescale 1ns/1ps
`default_nettype none
module spm_supply_and_power_mode_fsm (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_link_in,
  input wire logic link_cs_n_in,
  input wire logic link_mosi_in,
  output logic link_miso_out,
  output logic link_miso_oe_out,
  input wire logic supply_lockout_in,
  input wire logic supply_undervoltage_in,
  input wire logic supply_overvoltage_in,
  input wire logic io_supply_ok_in,
  input wire logic int_n_in,
  output logic int_n_out,
  output logic int_n_oe_out,
  input wire logic wake_n_in,
  output logic wake_n_out,
  output logic wake_n_oe_out,
  input wire logic lowpwr_cmd_in,
  input wire logic [spm_pkg::POLL_SEL_W-1:0] poll_sel_in,
  input wire logic [spm_pkg::CH_N-1:0] wake_en_in,
  input wire logic wake_pin_en_in,
  input wire logic comparator_change_in,
  input wire logic timer_wake_in,
  input wire logic [spm_pkg::CH_N-1:0] switch_sample_in,
  input wire logic [spm_pkg::CH_N-1:0] switch_held_in,
  input wire logic [4:0] fault_raw_in,
  input wire logic fault_clear_in,
  input wire logic lockout_flag_clear_in,
  input wire logic por_flag_clear_in,
  output logic [4:0] fault_flags_out,
  output logic lockout_flag_out,
  output logic por_flag_out,
  output logic current_limit_out,
  output logic sources_on_out,
  output logic analog_select_en_out,
  output logic fast_osc_en_out,
  output logic slow_osc_en_out,
  output logic serial_enable_out,
  output logic link_word_valid_out,
  output logic [7:0] link_word_out,
  output logic ready_out,
  output logic [2:0] state_out
);
  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic rst_meta_reg, rst_n_reg;
  // reset asserts at once, releases after two edges
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  localparam int SYNC_N = 8;
  wire [SYNC_N-1:0] async_vec = {timer_wake_in, comparator_change_in, io_supply_ok_in, wake_n_in,
                                 int_n_in, supply_overvoltage_in, supply_undervoltage_in, supply_lockout_in};
  logic [SYNC_N-1:0] sync1_reg, sync2_reg, sync3_reg;
  // the third stage only feeds edge detection, never the first stage
  always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sync1_reg <= 8'h39; // idle levels: pins high, io supply up, still in lockout
      sync2_reg <= 8'h39;
      sync3_reg <= 8'h39;
    end else begin
      sync1_reg <= async_vec;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  wire lockout_s = sync2_reg[0];
  wire uv_s = sync2_reg[1];
  wire ov_s = sync2_reg[2];
  wire int_fall = sync3_reg[3] & ~sync2_reg[3];
  wire wake_fall = sync3_reg[4] & ~sync2_reg[4];
  wire io_ok_s = sync2_reg[5];
  wire comp_s = sync2_reg[6];
  wire timer_s = sync2_reg[7];

  // ****************************************
  // link domain: serial word capture
  // ****************************************
  logic [7:0] lk_shift_reg;
  logic [2:0] lk_cnt_reg;
  logic lk_tog_reg;
  logic [7:0] lk_word_reg;
  // frame end is marked by chip select, so the link clock may stop outside frames
  always_ff @(posedge clk_link_in or posedge link_cs_n_in) begin
    if (link_cs_n_in) begin
      lk_cnt_reg <= 3'h0;
    end else begin
      lk_cnt_reg <= lk_cnt_reg + 3'h1;
    end
  end
  always_ff @(posedge clk_link_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      lk_shift_reg <= 8'h00;
      lk_word_reg <= 8'h00;
      lk_tog_reg <= 1'b0;
    end else if (!link_cs_n_in) begin
      lk_shift_reg <= {lk_shift_reg[6:0], link_mosi_in};
      if (lk_cnt_reg == 3'h7) begin
        lk_word_reg <= {lk_shift_reg[6:0], link_mosi_in};
        lk_tog_reg <= ~lk_tog_reg;
      end
    end
  end

  // ****************************************
  // word and chip select crossing into system clock
  // ****************************************
  logic [2:0] tog_sync_reg;
  logic [2:0] cs_sync_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      tog_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
    end else begin
      tog_sync_reg <= {tog_sync_reg[1:0], lk_tog_reg};
      cs_sync_reg <= {cs_sync_reg[1:0], link_cs_n_in};
    end
  end
  wire word_event = tog_sync_reg[2] ^ tog_sync_reg[1];
  wire cs_fall = cs_sync_reg[2] & ~cs_sync_reg[1];
  wire cs_active = ~cs_sync_reg[1];

  // ****************************************
  // state machine
  // ****************************************
  spm_pkg::spm_state_e state_reg, state_next;
  logic [spm_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [spm_pkg::CNT_W-1:0] act_reg;
  logic in_lockout_reg;
  logic frame_dirty_reg;

  wire any_wake_en = |wake_en_in;
  wire poll_change = |((switch_sample_in ^ switch_held_in) & wake_en_in);
  wire [spm_pkg::CNT_W-1:0] poll_period = spm_pkg::POLL_BASE_CYC << poll_sel_in;
  wire pin_wake = io_ok_s & (int_fall | cs_fall | (wake_fall & wake_pin_en_in));
  // the wake line can wake without io supply when enabled for it
  wire lp_wake = timer_s | comp_s | pin_wake | (wake_fall & wake_pin_en_in & ~io_ok_s);
  wire is_normal = (state_reg == spm_pkg::SPM_ST_NORMAL);
  wire is_lowpwr = (state_reg == spm_pkg::SPM_ST_LOWPWR);
  wire is_poll = (state_reg == spm_pkg::SPM_ST_POLL);
  wire act_done = (act_reg == '0);
  wire serial_ok = is_normal & io_ok_s & ~lockout_s & act_done;

  // next state; lockout overrides fuse read and normal only, not low power or polling
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      spm_pkg::SPM_ST_UV: begin
        cnt_next = '0;
        if (!lockout_s) begin
          state_next = spm_pkg::SPM_ST_FUSE;
        end
      end
      spm_pkg::SPM_ST_FUSE: begin
        cnt_next = cnt_reg + 24'h000001;
        if (lockout_s) begin
          state_next = spm_pkg::SPM_ST_UV;
        end else if (cnt_reg >= 24'(spm_pkg::FUSE_READ_CYC - 1)) begin
          state_next = spm_pkg::SPM_ST_NORMAL;
          cnt_next = '0;
        end
      end
      spm_pkg::SPM_ST_NORMAL: begin
        cnt_next = '0;
        if (lockout_s) begin
          state_next = spm_pkg::SPM_ST_UV;
        end else if (lowpwr_cmd_in && serial_ok) begin
          state_next = spm_pkg::SPM_ST_LOWPWR;
        end
      end
      spm_pkg::SPM_ST_LOWPWR: begin
        cnt_next = any_wake_en ? cnt_reg + 24'h000001 : '0;
        if (lp_wake) begin
          state_next = spm_pkg::SPM_ST_NORMAL;
          cnt_next = '0;
        end else if (any_wake_en && cnt_reg >= poll_period) begin
          state_next = spm_pkg::SPM_ST_POLL;
          cnt_next = '0;
        end
      end
      spm_pkg::SPM_ST_POLL: begin
        // polling holds its count while the supply is low
        cnt_next = (uv_s || lockout_s) ? cnt_reg : cnt_reg + 24'h000001;
        if (lp_wake) begin
          state_next = spm_pkg::SPM_ST_NORMAL;
          cnt_next = '0;
        end else if (!uv_s && !lockout_s && cnt_reg >= 24'(spm_pkg::POLL_ACTIVE_CYC - 1)) begin
          state_next = poll_change ? spm_pkg::SPM_ST_NORMAL : spm_pkg::SPM_ST_LOWPWR;
          cnt_next = '0;
        end
      end
    endcase
  end

  // state, counters; reset drops to lockout with defaults
  always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= spm_pkg::SPM_ST_UV;
      cnt_reg <= '0;
      act_reg <= 24'(spm_pkg::ACTIVE_TIME_CYC);
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      act_reg <= act_done ? act_reg : act_reg - 24'h000001;
    end
  end

  // ****************************************
  // sticky flags
  // ****************************************
  logic lockout_flag_reg, por_flag_reg, booted_reg;
  logic [4:0] fault_reg;
  // a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      in_lockout_reg <= 1'b1;
      lockout_flag_reg <= 1'b0;
      por_flag_reg <= 1'b1;
      fault_reg <= 5'h00;
      frame_dirty_reg <= 1'b0;
      booted_reg <= 1'b0;
    end else begin
      in_lockout_reg <= lockout_s;
      booted_reg <= booted_reg | (is_normal & act_done);
      if (in_lockout_reg && !lockout_s) begin
        lockout_flag_reg <= 1'b1;
      end else if (lockout_flag_clear_in && serial_ok) begin
        lockout_flag_reg <= 1'b0;
      end
      if (por_flag_clear_in && serial_ok) begin
        por_flag_reg <= 1'b0;
      end
      // faults only recorded in normal mode; low power sees none
      if (is_normal && |fault_raw_in) begin
        fault_reg <= fault_reg | fault_raw_in;
      end else if (fault_clear_in && serial_ok) begin
        fault_reg <= 5'h00;
      end
      // a frame touched by lockout is marked and its word discarded
      if (lockout_s && cs_active) begin
        frame_dirty_reg <= 1'b1;
      end else if (!cs_active) begin
        frame_dirty_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic word_valid_reg;
  logic [7:0] word_reg;
  // words accepted only outside lockout and in a clean frame
  always_ff @(posedge clk_sys_in or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      word_valid_reg <= 1'b0;
      word_reg <= 8'h00;
    end else begin
      word_valid_reg <= word_event & serial_ok & ~frame_dirty_reg & ~lockout_s;
      if (word_event && serial_ok && !frame_dirty_reg) begin
        word_reg <= lk_word_reg;
      end
    end
  end
  assign link_word_valid_out = word_valid_reg;
  assign link_word_out = word_reg;

  // serial output tristated in lockout and outside normal mode
  assign link_miso_oe_out = serial_ok & cs_active & ~frame_dirty_reg;
  assign link_miso_out = lk_shift_reg[7];
  assign serial_enable_out = serial_ok;

  // interrupt low from power on until first ready; never again, or low power would wake on its own pull
  wire ready = is_normal & act_done;
  assign ready_out = ready;
  assign int_n_out = 1'b0;
  assign int_n_oe_out = ~(ready | booted_reg);

  // wake line pulled low in normal mode
  assign wake_n_out = 1'b0;
  assign wake_n_oe_out = is_normal | (state_reg == spm_pkg::SPM_ST_FUSE);

  // sources off in lockout, limited in overvoltage, setup kept
  assign sources_on_out = (is_normal | is_poll) & ~lockout_s;
  assign current_limit_out = ov_s & ~lockout_s;
  assign analog_select_en_out = is_normal & ~lockout_s;

  // slow oscillator always on, fast one stopped in low power
  assign slow_osc_en_out = 1'b1;
  assign fast_osc_en_out = ~is_lowpwr;

  assign fault_flags_out = fault_reg;
  assign lockout_flag_out = lockout_flag_reg;
  assign por_flag_out = por_flag_reg;
  assign state_out = state_reg;
endmodule
`default_nettype wire

// *** spm_fsm_properties.sv ***
// port checker for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module spm_fsm_properties (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic link_miso_oe_out,
  input wire logic int_n_oe_out,
  input wire logic wake_n_oe_out,
  input wire logic lowpwr_cmd_in,
  input wire logic [spm_pkg::CH_N-1:0] wake_en_in,
  input wire logic [4:0] fault_flags_out,
  input wire logic lockout_flag_out,
  input wire logic sources_on_out,
  input wire logic fast_osc_en_out,
  input wire logic link_word_valid_out,
  input wire logic ready_out,
  input wire logic [2:0] state_out
);
  // cycles spent in fuse read, judged when normal mode starts
  logic [15:0] fuse_cnt_reg;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) fuse_cnt_reg <= 16'h0000;
    else fuse_cnt_reg <= (state_out == 3'h1) ? fuse_cnt_reg + 16'h0001 : 16'h0000;
  end
  // ready seen since reset; the interrupt line must be free from then on
  logic seen_ready_reg;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) seen_ready_reg <= 1'b0;
    else seen_ready_reg <= seen_ready_reg | ready_out;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  property p_miso_off; state_out == 3'h0 |-> !link_miso_oe_out; endproperty
  a_miso_off: assert property (p_miso_off) else $error("miso driven in lockout");
  property p_no_word; (state_out == 3'h0) [*8] |-> !link_word_valid_out; endproperty
  a_no_word: assert property (p_no_word) else $error("word taken in lockout");
  property p_sources_off; state_out == 3'h0 |-> !sources_on_out; endproperty
  a_sources_off: assert property (p_sources_off) else $error("sources on in lockout");
  property p_int_held; !seen_ready_reg && !ready_out |-> int_n_oe_out; endproperty
  a_int_held: assert property (p_int_held) else $error("interrupt released early");
  property p_int_free; seen_ready_reg |-> !int_n_oe_out; endproperty
  a_int_free: assert property (p_int_free) else $error("interrupt held after ready");
  property p_wake_low; state_out == 3'h3 |-> wake_n_oe_out; endproperty
  a_wake_low: assert property (p_wake_low) else $error("wake line not driven");
  // a stretch of +-8 cycles covers the sampling offset of the counter
  property p_fuse_time; state_out == 3'h3 && $past(state_out) == 3'h1 |->
    int'(fuse_cnt_reg) > spm_pkg::FUSE_READ_CYC - 9 && int'(fuse_cnt_reg) < spm_pkg::FUSE_READ_CYC + 9; endproperty
  a_fuse_time: assert property (p_fuse_time) else $error("fuse read length wrong");
  property p_lp_cmd; state_out == 3'h3 ##1 state_out == 3'h2 |->
    $past(lowpwr_cmd_in) || $past(lowpwr_cmd_in, 2) || $past(lowpwr_cmd_in, 3); endproperty
  a_lp_cmd: assert property (p_lp_cmd) else $error("low power without command");
  property p_lp_frozen; state_out == 3'h2 && $past(state_out) == 3'h2 |->
    $stable(fault_flags_out) && !fast_osc_en_out; endproperty
  a_lp_frozen: assert property (p_lp_frozen) else $error("activity in low power");
  property p_no_poll; state_out == 3'h2 ##1 state_out == 3'h6 |-> $past(wake_en_in) != '0; endproperty
  a_no_poll: assert property (p_no_poll) else $error("poll with wake disabled");
  property p_flag_set; state_out == 3'h0 ##1 state_out == 3'h1 |-> ##[0:3] lockout_flag_out; endproperty
  a_flag_set: assert property (p_flag_set) else $error("lockout flag missing");
endmodule
bind spm_supply_and_power_mode_fsm spm_fsm_properties chk_u (.*);
`default_nettype wire

// *** spm_host_model.sv ***
// host side: serial master and the pulled-up open-drain lines
`timescale 1ns/1ps
`default_nettype none
module spm_host_model (
  input wire logic int_n_out,
  input wire logic int_n_oe_out,
  input wire logic wake_n_out,
  input wire logic wake_n_oe_out,
  output logic clk_link_out,
  output logic cs_n_out,
  output logic mosi_out,
  output logic int_n_line_out,
  output logic wake_n_line_out
);
  logic int_pull_reg = 1'b0;
  logic wake_pull_reg = 1'b0;
  // pull-ups win unless some party sinks the line
  assign int_n_line_out = !((int_n_oe_out && !int_n_out) || int_pull_reg);
  assign wake_n_line_out = !((wake_n_oe_out && !wake_n_out) || wake_pull_reg);
  initial begin
    clk_link_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // one msb-first frame; clock still outside it, data turned round after
  task automatic send(input logic [7:0] b);
    cs_n_out = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = b[i];
      #6 clk_link_out = 1'b1;
      #6 clk_link_out = 1'b0;
    end
    mosi_out = ~b[0];
    #6 cs_n_out = 1'b1;
    #6;
  endtask
endmodule
`default_nettype wire

// *** spm_supply_and_power_mode_fsm_tb.sv ***
// self-checking bench for the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module spm_supply_and_power_mode_fsm_tb;
  logic clk_sys_in = 1'b0, nrst_in = 1'b0, clk_link_in, link_cs_n_in, link_mosi_in, link_miso_out, link_miso_oe_out;
  logic supply_lockout_in = 1'b1, supply_undervoltage_in = 1'b0, supply_overvoltage_in = 1'b0, io_supply_ok_in = 1'b1;
  logic int_n_in, int_n_out, int_n_oe_out, wake_n_in, wake_n_out, wake_n_oe_out, lowpwr_cmd_in = 1'b0;
  logic [2:0] poll_sel_in = 3'h0, state_out;
  logic [spm_pkg::CH_N-1:0] wake_en_in = 22'h3FFFFF, switch_sample_in = 22'h0, switch_held_in = 22'h0;
  logic wake_pin_en_in = 1'b1, comparator_change_in = 1'b0, timer_wake_in = 1'b0, fault_clear_in = 1'b0;
  logic lockout_flag_clear_in = 1'b0, por_flag_clear_in = 1'b0, lockout_flag_out, por_flag_out, current_limit_out;
  logic [4:0] fault_raw_in = 5'h00, fault_flags_out;
  logic sources_on_out, analog_select_en_out, fast_osc_en_out, slow_osc_en_out, serial_enable_out;
  logic link_word_valid_out, ready_out;
  logic [7:0] link_word_out;
  logic [15:0] lfsr = 16'h4FE0;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int tests_run = 0;
  spm_host_model host_u (.int_n_out(int_n_out), .int_n_oe_out(int_n_oe_out), .wake_n_out(wake_n_out),
    .wake_n_oe_out(wake_n_oe_out), .clk_link_out(clk_link_in), .cs_n_out(link_cs_n_in),
    .mosi_out(link_mosi_in), .int_n_line_out(int_n_in), .wake_n_line_out(wake_n_in));
  spm_supply_and_power_mode_fsm dut_u (.*);
  always #4 clk_sys_in = ~clk_sys_in;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // random byte over the link; noted as expected only where it must arrive
  task automatic send_byte(input logic take);
    lfsr = lfsr_next(lfsr);
    if (take) exp_q.push_back(lfsr[7:0]);
    host_u.send(lfsr[7:0]);
    tick(10);
  endtask
  // every received word is matched against the oldest note
  always @(posedge clk_sys_in) begin
    if (link_word_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check("stray word", 1'b1, 1'b0);
      else check("word", link_word_out, exp_q.pop_front());
    end
  end
  initial begin
    #500000;
    check("watchdog", 1'b0, 1'b1);
    give_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    tick(12);
    check("int at reset", int_n_in, 1'b0);
    nrst_in <= 1'b1;
    supply_lockout_in <= 1'b0;
    tick(3);
    check("por flag", por_flag_out, 1'b1);
    check("faults reset", fault_flags_out, 5'h00);
    repeat (8000) if (state_out !== 3'h3) @(posedge clk_sys_in);
    check("normal", state_out, 3'h3);
    check("wake pin", wake_n_in, 1'b0);
    // the host keeps off the link until the device says it is ready
    repeat (14000) if (ready_out !== 1'b1) @(posedge clk_sys_in);
    check("int free", int_n_in, 1'b1);
    check("serial on", serial_enable_out, 1'b1);
    check("sources on", sources_on_out, 1'b1);
    check("mux on", analog_select_en_out, 1'b1);
    por_flag_clear_in <= 1'b1;
    tick(1);
    por_flag_clear_in <= 1'b0;
    tick(1);
    check("por cleared", por_flag_out, 1'b0);
    repeat (3) send_byte(1'b1);
    fork
      host_u.send(8'hA5);
      begin
        #40;
        @(posedge clk_sys_in);
        supply_lockout_in <= 1'b1;
      end
    join
    tick(8);
    check("miso off", link_miso_oe_out, 1'b0);
    check("serial off", serial_enable_out, 1'b0);
    check("sources off", sources_on_out, 1'b0);
    check("mux off", analog_select_en_out, 1'b0);
    send_byte(1'b0);
    supply_lockout_in <= 1'b0;
    repeat (14000) if (ready_out !== 1'b1) @(posedge clk_sys_in);
    check("lockout flag", lockout_flag_out, 1'b1);
    io_supply_ok_in <= 1'b0;
    send_byte(1'b0);
    check("state kept", state_out, 3'h3);
    io_supply_ok_in <= 1'b1;
    send_byte(1'b1);
    supply_overvoltage_in <= 1'b1;
    tick(8);
    check("limit", current_limit_out, 1'b1);
    supply_overvoltage_in <= 1'b0;
    tick(8);
    check("limit off", current_limit_out, 1'b0);
    fault_raw_in <= 5'h01 << (lfsr % 5);
    tick(1);
    fault_raw_in <= 5'h00;
    tick(4);
    check("fault", fault_flags_out, 5'h01 << (lfsr % 5));
    fault_clear_in <= 1'b1;
    tick(1);
    fault_clear_in <= 1'b0;
    tick(3);
    // sleep with wake enables off, then wake by timer, comparator, int and wake line in turn
    for (int s = 0; s < 4; s++) begin
      wake_en_in <= 22'h000000;
      lowpwr_cmd_in <= 1'b1;
      tick(1);
      lowpwr_cmd_in <= 1'b0;
      tick(6);
      fault_raw_in <= 5'h1F;
      tick(1);
      fault_raw_in <= 5'h00;
      tick(3000);
      check("asleep", state_out, 3'h2);
      check("no fault", fault_flags_out, 5'h00);
      check("fast osc", fast_osc_en_out, 1'b0);
      check("slow osc", slow_osc_en_out, 1'b1);
      check("wake free", wake_n_in, 1'b1);
      check("int idle", int_n_in, 1'b1);
      case (s)
        0: timer_wake_in <= 1'b1;
        1: comparator_change_in <= 1'b1;
        2: host_u.int_pull_reg <= 1'b1;
        default: host_u.wake_pull_reg <= 1'b1;
      endcase
      tick(50);
      check("awake", state_out, 3'h3);
      {timer_wake_in, comparator_change_in} <= 2'h0;
      host_u.int_pull_reg <= 1'b0;
      host_u.wake_pull_reg <= 1'b0;
      tick(4);
    end
    poll_sel_in <= {2'h0, lfsr[0]};
    wake_en_in <= 22'h3FFFFF;
    switch_held_in <= {lfsr[5:0], lfsr};
    switch_sample_in <= {lfsr[5:0], lfsr};
    lowpwr_cmd_in <= 1'b1;
    tick(1);
    lowpwr_cmd_in <= 1'b0;
    repeat (4200) if (state_out !== 3'h6) @(posedge clk_sys_in);
    check("polling", state_out, 3'h6);
    check("poll sources", sources_on_out, 1'b1);
    tick(40);
    check("back asleep", state_out, 3'h2);
    supply_undervoltage_in <= 1'b1;
    switch_sample_in <= ~{lfsr[5:0], lfsr};
    tick(4400);
    check("paused", state_out, 3'h6);
    supply_undervoltage_in <= 1'b0;
    repeat (4200) if (state_out !== 3'h3) @(posedge clk_sys_in);
    check("woken", state_out, 3'h3);
    check("words left", exp_q.size(), 0);
    give_verdict();
  end
endmodule
`default_nettype wire
